// ---- src/usart_transmitter.sv ----
// Transmit half of an asynchronous serial port with a two-entry write buffer,
// a holding register, a shift register, break and idle frames and a bit clock.
// Assumes control inputs come from logic on clk_sys_in; clear_to_send_n_in is a pin.
//
// Contract
// - Enabled transmitter with nothing to send holds the line high.
// - Disabled transmitter releases the pin by dropping its output enable.
// - Frames carry 8 or 9 data bits per the word-length control.
// - Start bit low, stop bits high, data least significant bit first.
// - Two-bit stop field chooses 0.5, 1, 1.5 or 2 stop bits; 1 default.
// - Enabling the transmitter first sends one all-ones idle frame.
// - Break is 10 low bits, or 11 with 9-bit words, then stop.
// - Break request sends break after current frame; cleared at break's stop bit.
// - After a break, one or two high stop bits follow.
// - Request cleared before break start sends nothing; re-set only after stop.
// - Only a data write clears the buffer-empty flag.
// - Buffer-empty sets when holding word moves to shifter; may interrupt.
// - Write during transmission waits in holding buffer until frame ends.
// - Write while idle starts transmission and sets buffer-empty at once.
// - Complete flag sets after stop bit with buffer empty; may interrupt.
// - Complete flag clears on status read then data write, or write zero.
// - Dropping enable mid-frame stops the baud counter and loses the frame.
// - Sync bit clock only during data bits; polarity, phase selectable.
// - High clear-to-send blocks starting the next data frame.
// - Request-to-send driven low when ready to receive.
// - Baud divider 12-bit integer, 4-bit fraction; runs only when enabled.
`timescale 1ns/10ps

module usart_transmitter #(
  parameter int unsigned DEPTH = 2
) (
  input  wire logic                                 clk_sys_in,
  input  wire logic                                 reset_in,
  input  wire usart_tx_pkg::tx_ctrl_s               ctrl_in,
  input  wire usart_tx_pkg::baud_div_s              baud_div_in,
  input  wire logic                                 wr_valid_in,
  input  wire logic [usart_tx_pkg::WORD_W-1:0]      wr_data_in,
  input  wire logic                                 status_read_in,
  input  wire logic                                 tx_done_clear_in,
  input  wire logic                                 break_set_in,
  input  wire logic                                 break_clear_in,
  input  wire logic                                 tx_empty_irq_on_in,
  input  wire logic                                 tx_done_irq_on_in,
  input  wire logic                                 clear_to_send_n_in,
  input  wire logic                                 rx_ready_in,
  output logic                                      wr_ready_out,
  output logic                                      tx_out,
  output logic                                      tx_oe_out,
  output logic                                      sync_bit_strobe_out,
  output logic                                      tx_buffer_empty_flag_out,
  output logic                                      tx_done_flag_out,
  output logic                                      send_break_request_out,
  output logic                                      irq_out,
  output logic                                      request_to_send_n_out
);

  localparam int unsigned PTR_W = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_IDLE  = 5'h02,
    ST_START = 5'h04,
    ST_DATA  = 5'h08,
    ST_STOP  = 5'h10
  } tx_state_e;

  // ---------------------------------------------------------------
  // Write buffer
  // ---------------------------------------------------------------
  logic [usart_tx_pkg::WORD_W-1:0] fifo_q [DEPTH];
  logic [PTR_W-1:0]                wptr_q;
  logic [PTR_W-1:0]                rptr_q;
  logic [PTR_W:0]                  count_q;
  logic                            push;
  logic                            pop;
  logic                            hold_full_q;

  // The holding register drains the buffer, so a stalled shifter fills it and
  // wr_ready_out falls; the writer sees back-pressure instead of a lost word.
  assign push = wr_valid_in & wr_ready_out;
  assign pop  = (count_q != '0) & ~hold_full_q;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == PTR_W'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == PTR_W'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
      end
      count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  // Storage has no reset; count_q alone says what is valid.
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      fifo_q[wptr_q] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wr_ready_out <= 1'b0;
    end else begin
      wr_ready_out <= (count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop)) < (PTR_W+1)'(DEPTH);
    end
  end

  // ---------------------------------------------------------------
  // Holding buffer, flow control input and break request
  // ---------------------------------------------------------------
  logic [usart_tx_pkg::WORD_W-1:0] hold_q;
  logic                            cts_s1_q;
  logic                            cts_s2_q;
  logic                            brk_q;
  tx_state_e                       state_q;
  usart_tx_pkg::frame_kind_e       kind_q;
  logic                            load_data;
  logic                            load_break;
  logic                            stop_done;
  logic                            bit_done;
  logic                            last_bit;
  logic                            te_on;

  assign te_on = ctrl_in.port_unit_on & ctrl_in.transmit_enable_bit;
  // Break takes the slot before queued data; data waits while the peer blocks.
  assign load_break = (state_q == ST_IDLE) & brk_q;
  assign load_data  = (state_q == ST_IDLE) & ~brk_q & hold_full_q
                      & ~(ctrl_in.cts_flow_on & cts_s2_q);

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      hold_full_q <= 1'b0;
      hold_q      <= '0;
    end else if (pop) begin
      hold_full_q <= 1'b1;
      hold_q      <= fifo_q[rptr_q];
    end else if (load_data) begin
      hold_full_q <= 1'b0;
    end
  end

  // Two flops before the clear-to-send pin is looked at.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cts_s1_q <= usart_tx_pkg::RST_CTS_N;
      cts_s2_q <= usart_tx_pkg::RST_CTS_N;
    end else begin
      cts_s1_q <= clear_to_send_n_in;
      cts_s2_q <= cts_s1_q;
    end
  end

  // Hardware clears the request as the break's stop period begins; a fresh
  // set in that same cycle wins so no request is lost.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      brk_q <= 1'b0;
    end else if (break_set_in) begin
      brk_q <= 1'b1;
    end else if (break_clear_in) begin
      brk_q <= 1'b0;
    end else if (state_q == ST_DATA && kind_q == usart_tx_pkg::KIND_BREAK && bit_done
                 && last_bit) begin
      brk_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Baud timing in half bit periods
  // ---------------------------------------------------------------
  logic [usart_tx_pkg::BAUD_DIV_W-2:0] cnt_q;
  logic [usart_tx_pkg::BAUD_DIV_W-2:0] half_len;
  logic [2:0]                          halves_q;
  logic [2:0]                          stop_halves;
  logic                                half_tick;
  logic                                busy;
  logic [3:0]                          bit_cnt_q;
  logic [3:0]                          last_idx;

  // Divider counts sixteenths of a clock-per-bit figure, i.e. {int,frac} clocks
  // per bit; the half period truncates, so odd divisors run one clock short.
  always_comb begin
    half_len = {baud_div_in.int_part, baud_div_in.frac_part[3:1]};
    if (half_len == '0) begin
      half_len = 15'h0001;
    end
  end

  always_comb begin
    unique case (ctrl_in.stop_sel)
      usart_tx_pkg::STOP_SEL_0P5: stop_halves = usart_tx_pkg::HALVES_0P5;
      usart_tx_pkg::STOP_SEL_2:   stop_halves = usart_tx_pkg::HALVES_2;
      usart_tx_pkg::STOP_SEL_1P5: stop_halves = usart_tx_pkg::HALVES_1P5;
      default:                    stop_halves = usart_tx_pkg::HALVES_1;
    endcase
    // After a break only one or two whole stop bits are used.
    if (kind_q == usart_tx_pkg::KIND_BREAK) begin
      stop_halves = (ctrl_in.stop_sel == usart_tx_pkg::STOP_SEL_2)
                    ? usart_tx_pkg::HALVES_2 : usart_tx_pkg::HALVES_1;
    end
  end

  // Break adds one low bit in the stop slot: 10 or 11 low bits in all.
  assign last_idx  = (ctrl_in.word_nine ? 4'(usart_tx_pkg::WORD_BITS_9 - 1)
                                        : 4'(usart_tx_pkg::WORD_BITS_8 - 1))
                     + ((kind_q == usart_tx_pkg::KIND_BREAK) ? 4'h1 : 4'h0);
  assign last_bit  = (bit_cnt_q == last_idx);
  assign busy      = (state_q == ST_START) | (state_q == ST_DATA) | (state_q == ST_STOP);
  assign half_tick = busy & (cnt_q == half_len - 1'b1);
  assign bit_done  = half_tick & (halves_q == 3'h1);
  assign stop_done = half_tick & (halves_q == stop_halves - 1'b1);

  // Counter is held clear outside frames and whenever the enable drops.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !te_on || !busy) begin
      cnt_q    <= '0;
      halves_q <= '0;
    end else if (half_tick) begin
      cnt_q    <= '0;
      halves_q <= ((state_q != ST_STOP && bit_done) || (state_q == ST_STOP && stop_done))
                  ? 3'h0 : halves_q + 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  logic [usart_tx_pkg::WORD_W-1:0] shift_q;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !te_on) begin
      state_q   <= ST_OFF;
      kind_q    <= usart_tx_pkg::KIND_IDLE;
      bit_cnt_q <= '0;
      shift_q   <= '0;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          state_q <= ST_START;
          kind_q  <= usart_tx_pkg::KIND_IDLE;
        end
        ST_IDLE: begin
          if (load_break) begin
            state_q <= ST_START;
            kind_q  <= usart_tx_pkg::KIND_BREAK;
          end else if (load_data) begin
            state_q <= ST_START;
            kind_q  <= usart_tx_pkg::KIND_DATA;
            shift_q <= hold_q;
          end
        end
        ST_START: begin
          if (bit_done) begin
            state_q   <= ST_DATA;
            bit_cnt_q <= '0;
          end
        end
        ST_DATA: begin
          if (bit_done) begin
            shift_q <= shift_q >> 1;
            if (last_bit) begin
              state_q <= ST_STOP;
            end else begin
              bit_cnt_q <= bit_cnt_q + 1'b1;
            end
          end
        end
        ST_STOP: begin
          if (stop_done) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Line, enable and bit clock
  // ---------------------------------------------------------------
  logic line_d;
  logic clk_active;

  always_comb begin
    unique case (state_q)
      ST_START: line_d = (kind_q == usart_tx_pkg::KIND_IDLE);
      ST_DATA:  line_d = (kind_q == usart_tx_pkg::KIND_DATA) ? shift_q[0]
                         : (kind_q == usart_tx_pkg::KIND_IDLE);
      default:  line_d = 1'b1;
    endcase
  end

  // Clock pulses only in data bits of data frames; the last may be dropped.
  assign clk_active = ctrl_in.sync_mode & (state_q == ST_DATA)
                      & (kind_q == usart_tx_pkg::KIND_DATA)
                      & ~(last_bit & ~ctrl_in.last_bit_pulse);

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_out              <= usart_tx_pkg::RST_LINE;
      tx_oe_out           <= 1'b0;
      sync_bit_strobe_out <= 1'b0;
    end else begin
      tx_out              <= line_d;
      tx_oe_out           <= te_on;
      sync_bit_strobe_out <= ctrl_in.clk_polarity
                             ^ (clk_active & (halves_q[0] ^ ctrl_in.clk_phase));
    end
  end

  // ---------------------------------------------------------------
  // Status flags and interrupt
  // ---------------------------------------------------------------
  logic rd_seen_q;
  logic done_set;

  assign done_set = (state_q == ST_STOP) & stop_done & ~hold_full_q;

  // A status read arms the clear; the next accepted write fires it.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_seen_q <= 1'b0;
    end else if (status_read_in) begin
      rd_seen_q <= 1'b1;
    end else if (push) begin
      rd_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_done_flag_out <= usart_tx_pkg::RST_TX_DONE;
    end else if (done_set) begin
      tx_done_flag_out <= 1'b1;
    end else if ((rd_seen_q && push) || tx_done_clear_in) begin
      tx_done_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_buffer_empty_flag_out <= usart_tx_pkg::RST_TX_EMPTY;
      send_break_request_out   <= 1'b0;
      irq_out                  <= 1'b0;
      request_to_send_n_out    <= 1'b1;
    end else begin
      tx_buffer_empty_flag_out <= ~hold_full_q;
      send_break_request_out   <= brk_q;
      irq_out                  <= (~hold_full_q & tx_empty_irq_on_in)
                                  | (tx_done_flag_out & tx_done_irq_on_in);
      request_to_send_n_out    <= ~rx_ready_in;
    end
  end

endmodule // usart_transmitter

// ---- src/usart_tx_pkg.sv ----
// Shared constants and carriers of the serial transmit block.
// Assumes one system clock; every item here is used by name only.
package usart_tx_pkg;

  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int unsigned BAUD_INT_W   = 12;   // Integer part of the baud divider.
  localparam int unsigned BAUD_FRAC_W  = 4;    // Fraction part of the baud divider.
  localparam int unsigned BAUD_DIV_W   = 16;   // Whole divider in sixteenths.
  localparam int unsigned WORD_W       = 9;    // Widest data word.
  localparam int unsigned WORD_BITS_8  = 8;    // Data bits with the short word length.
  localparam int unsigned WORD_BITS_9  = 9;    // Data bits with the long word length.
  localparam int unsigned STOP_FIELD_HI = 13;  // Stop-bit field position in control_reg_two.
  localparam int unsigned STOP_FIELD_LO = 12;

  // ---------------------------------------------------------------
  // Stop-bit encodings, counted in half bit periods
  // ---------------------------------------------------------------
  localparam logic [1:0] STOP_SEL_1    = 2'h0;  // Default: one stop bit.
  localparam logic [1:0] STOP_SEL_0P5  = 2'h1;
  localparam logic [1:0] STOP_SEL_2    = 2'h2;
  localparam logic [1:0] STOP_SEL_1P5  = 2'h3;
  localparam logic [2:0] HALVES_0P5    = 3'h1;
  localparam logic [2:0] HALVES_1      = 3'h2;
  localparam logic [2:0] HALVES_1P5    = 3'h3;
  localparam logic [2:0] HALVES_2      = 3'h4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RST_TX_EMPTY  = 1'b1;  // Holding buffer starts empty.
  localparam logic RST_TX_DONE   = 1'b1;  // Nothing pending after reset.
  localparam logic RST_LINE      = 1'b1;  // Line idles high.
  localparam logic RST_CTS_N     = 1'b1;  // Treat flow control as blocking until sampled.

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_IDLE  = 2'h0,
    KIND_DATA  = 2'h1,
    KIND_BREAK = 2'h2
  } frame_kind_e;

  typedef struct packed {
    logic       port_unit_on;
    logic       transmit_enable_bit;
    logic       word_nine;
    logic [1:0] stop_sel;
    logic       sync_mode;
    logic       clk_polarity;
    logic       clk_phase;
    logic       last_bit_pulse;
    logic       cts_flow_on;
  } tx_ctrl_s;

  typedef struct packed {
    logic [BAUD_INT_W-1:0]  int_part;
    logic [BAUD_FRAC_W-1:0] frac_part;
  } baud_div_s;

endpackage : usart_tx_pkg

// ---- dv/usart_tx_monitor.sv ----
// Port checker for the serial transmitter, attached by bind.
// Assumes all inputs are sampled on clk_sys_in and reset by reset_in.
`timescale 1ns/10ps
module usart_tx_monitor (
  input wire logic                   clk_sys_in,
  input wire logic                   reset_in,
  input wire usart_tx_pkg::tx_ctrl_s ctrl_in,
  input wire logic                   break_set_in,
  input wire logic                   break_clear_in,
  input wire logic                   tx_empty_irq_on_in,
  input wire logic                   tx_done_irq_on_in,
  input wire logic                   rx_ready_in,
  input wire logic                   tx_out,
  input wire logic                   tx_oe_out,
  input wire logic                   tx_buffer_empty_flag_out,
  input wire logic                   send_break_request_out,
  input wire logic                   irq_out,
  input wire logic                   request_to_send_n_out
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // A break request that ended by itself rather than by software.
  sequence brk_end_s;
    $fell(send_break_request_out) && !$past(break_clear_in, 2) && tx_oe_out;
  endsequence
  // A low or undriven line lasting at least eight clocks.
  sequence low_run_s;
    (!tx_out || !tx_oe_out) [*8];
  endsequence
  a_pin_release: assert property (!ctrl_in.transmit_enable_bit |=> !tx_oe_out)
    else $error("pin still driven while disabled");
  a_start_low: assert property ($fell(tx_out) && tx_oe_out |-> low_run_s)
    else $error("start bit too short");
  a_brk_stop_high: assert property (brk_end_s |-> ##[0:2] tx_out [*8])
    else $error("no high stop after break");
  a_brk_set: assert property (break_set_in && !break_clear_in |=> ##1 send_break_request_out)
    else $error("break request not taken");
  a_brk_cancel: assert property (break_clear_in && !break_set_in |=> ##1
    !send_break_request_out) else $error("break request not dropped");
  a_rts_follow: assert property (!$past(reset_in) && $stable(rx_ready_in) |->
    request_to_send_n_out == !rx_ready_in) else $error("request-to-send wrong");
  a_irq_quiet: assert property ((!tx_empty_irq_on_in && !tx_done_irq_on_in) [*2] |-> !irq_out)
    else $error("interrupt while both masked");
  a_irq_raise: assert property ((tx_buffer_empty_flag_out && tx_empty_irq_on_in) [*2] |-> irq_out)
    else $error("empty interrupt missing");
endmodule // usart_tx_monitor
bind usart_transmitter usart_tx_monitor i_mon (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
  .ctrl_in(ctrl_in), .break_set_in(break_set_in), .break_clear_in(break_clear_in),
  .tx_empty_irq_on_in(tx_empty_irq_on_in), .tx_done_irq_on_in(tx_done_irq_on_in),
  .rx_ready_in(rx_ready_in), .tx_out(tx_out), .tx_oe_out(tx_oe_out),
  .tx_buffer_empty_flag_out(tx_buffer_empty_flag_out), .irq_out(irq_out),
  .send_break_request_out(send_break_request_out), .request_to_send_n_out(request_to_send_n_out));

// ---- dv/serial_line_sink.sv ----
// Far-side serial device: decodes frames on the line and drives clear-to-send.
// Assumes a pulled-up line and a bit time of BIT system clocks.
`timescale 1ns/10ps
module serial_line_sink #(
  parameter int BIT = 40
) (
  input  wire logic  clk_sys_in,
  input  wire logic  reset_in,
  input  wire logic  line_in,
  input  wire logic  nine_in,
  input  wire logic  stall_in,
  output logic       clear_to_send_n_out,
  output logic [8:0] word_out,
  output int         frames_out,
  output int         breaks_out,
  output int         gap_out,
  output int         low_out
);
  // ------------------------------------------------------------
  // Decoder
  // ------------------------------------------------------------
  int         cnt, k, since, lows;
  logic       busy, prev;
  logic [8:0] sh;
  // A stalled device holds clear-to-send high to keep the next frame back.
  assign clear_to_send_n_out = stall_in;
  // Data bits are sampled mid-bit; the stop slot early, so half stop bits pass.
  always @(posedge clk_sys_in) begin
    prev <= line_in;
    since <= since + 1;
    lows <= line_in ? 0 : lows + 1;
    if (line_in && !prev) low_out <= lows;
    k = cnt / BIT;
    if (reset_in) begin
      busy <= 1'h0;
      frames_out <= 0;
      breaks_out <= 0;
    end else if (!busy && prev && !line_in) begin
      busy <= 1'h1;
      cnt <= 1;
      sh <= '0;
      gap_out <= since;
      since <= 1;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (k >= 1 && k <= 8 + nine_in && cnt % BIT == BIT / 2) sh[k-1] <= line_in;
      if (k == 9 + nine_in && cnt % BIT == BIT / 4) begin
        busy <= 1'h0;
        word_out <= sh;
        if (line_in) frames_out <= frames_out + 1;
        else breaks_out <= breaks_out + 1;
      end
    end
  end
endmodule // serial_line_sink

// ---- dv/testbench.sv ----
// Self-checking bench for the serial transmitter and its far-side model.
// Assumes a 4 ns system clock and a bit time of 40 clocks, 160 ns.
`timescale 1ns/10ps
module testbench;
  // ------------------------------------------------------------
  // Stimulus, models and checks
  // ------------------------------------------------------------
  typedef struct {logic nine; logic [1:0] stop; logic [8:0] w; int halves;} row_t;
  localparam int BIT = 40;
  row_t rows [4] = '{'{1'h0, usart_tx_pkg::STOP_SEL_1, 9'h03C, 2},
    '{1'h1, usart_tx_pkg::STOP_SEL_2, 9'h1A5, 4}, '{1'h0, usart_tx_pkg::STOP_SEL_0P5, 9'h0C3, 1},
    '{1'h1, usart_tx_pkg::STOP_SEL_1P5, 9'h15A, 3}};
  usart_tx_pkg::tx_ctrl_s ctrl = '0;
  logic clk_sys_in = 1'h0, reset_in = 1'h1, wr_valid = 1'h0, rd_stat = 1'h0, done_clr = 1'h0;
  logic brk_set = 1'h0, brk_clr = 1'h0, empty_on = 1'h0, done_on = 1'h0, rx_ready = 1'h0;
  logic stall = 1'h0, wr_ready, tx, oe, strobe, empty, done, brk, irq, rts_n, cts_n, pin;
  logic [8:0] wr_data = '0, got, exp;
  int frames, breaks, gap, lows, e, f, t0, cyc = 0, rises = 0, miscompares = 0, compares = 0;
  // Clock, cycle count and bit-clock edges; the line has a pull-up.
  always #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cyc <= cyc + 1;
  always @(posedge strobe) rises <= rises + 1;
  assign pin = oe ? tx : 1'h1;
  usart_transmitter i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ctrl_in(ctrl),
    .baud_div_in(16'h0028), .wr_valid_in(wr_valid), .wr_data_in(wr_data),
    .status_read_in(rd_stat), .tx_done_clear_in(done_clr), .break_set_in(brk_set),
    .break_clear_in(brk_clr), .tx_empty_irq_on_in(empty_on), .tx_done_irq_on_in(done_on),
    .clear_to_send_n_in(cts_n), .rx_ready_in(rx_ready), .wr_ready_out(wr_ready), .tx_out(tx),
    .tx_oe_out(oe), .sync_bit_strobe_out(strobe), .tx_buffer_empty_flag_out(empty),
    .tx_done_flag_out(done), .send_break_request_out(brk), .irq_out(irq),
    .request_to_send_n_out(rts_n));
  serial_line_sink #(.BIT(BIT)) i_far (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .line_in(pin), .nine_in(ctrl.word_nine), .stall_in(stall), .clear_to_send_n_out(cts_n),
    .word_out(got), .frames_out(frames), .breaks_out(breaks), .gap_out(gap), .low_out(lows));
  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, want, seen);
    end
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic pulse(ref logic s);
    tick(1);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  // A write holds valid and data until the edge that sees ready high.
  task automatic put(logic [8:0] w);
    int i;
    tick(1);
    wr_data = w;
    wr_valid = 1'h1;
    for (i = 0; i < 8000 && wr_ready !== 1'h1; i++) tick(1);
    if (i == 8000) begin miscompares++; summarize(); end
    tick(1);
    wr_valid = 1'h0;
  endtask
  task automatic wait_cnt(ref int c, input int t);
    int i;
    for (i = 0; i < 8000 && c < t; i++) tick(1);
    if (i == 8000) begin miscompares++; summarize(); end
  endtask
  task automatic wait_low();
    int i;
    for (i = 0; i < 8000 && pin !== 1'h0; i++) tick(1);
    if (i == 8000) begin miscompares++; summarize(); end
  endtask
  initial begin
    ctrl.port_unit_on = 1'h1;
    ctrl.cts_flow_on = 1'h1;
    tick(12);
    check("reset outputs", {oe, empty, done, brk, rts_n, tx, wr_ready}, 7'h36);
    reset_in = 1'h0;
    ctrl.transmit_enable_bit = 1'h1;
    t0 = cyc;
    put(9'h0A5);
    wait_low();
    check("idle frame first", cyc - t0 >= 10 * BIT, 1);
    wait_cnt(frames, 1);
    check("first word", got, 9'h0A5);
    foreach (rows[r]) begin
      tick(BIT);
      ctrl.word_nine = rows[r].nine;
      ctrl.stop_sel = rows[r].stop;
      exp = rows[r].nine ? ~rows[r].w : {1'h0, ~rows[r].w[7:0]};
      f = frames;
      put(rows[r].w);
      put(~rows[r].w);
      tick(4);
      check("holding full", empty, 0);
      wait_cnt(frames, f + 2);
      check("data bits", got, exp);
      e = BIT * (rows[r].nine ? 10 : 9) + BIT / 2 * rows[r].halves + 1;
      check("frame length", gap >= e - 1 && gap <= e + 2, 1);
    end
    for (int n9 = 0; n9 < 2; n9++) begin
      tick(3 * BIT);
      ctrl.word_nine = n9[0];
      ctrl.stop_sel = usart_tx_pkg::STOP_SEL_1;
      e = breaks;
      f = frames;
      pulse(brk_set);
      put(9'h155);
      wait_cnt(breaks, e + 1);
      tick(BIT);
      check("break length", lows >= BIT * (10 + n9) - 1 && lows <= BIT * (10 + n9) + 2, 1);
      check("break request end", brk, 0);
      wait_cnt(frames, f + 1);
      check("word after break", got, n9[0] ? 9'h155 : 9'h055);
    end
    e = breaks;
    f = frames;
    put(9'h0F0);
    wait_low();
    pulse(brk_set);
    pulse(brk_clr);
    wait_cnt(frames, f + 1);
    tick(20 * BIT);
    check("cancelled break", breaks, e);
    stall = 1'h1;
    tick(4);
    f = frames;
    for (int i = 1; i < 4; i++) put(9'h011 * i[8:0]);
    tick(8);
    check("buffer refuses", wr_ready, 0);
    tick(12 * BIT);
    check("held by flow control", frames, f);
    stall = 1'h0;
    for (int i = 1; i < 4; i++) begin
      wait_cnt(frames, f + i);
      check("drained word", got, 9'h011 * i);
    end
    tick(3 * BIT);
    rx_ready = 1'h1;
    done_on = 1'h1;
    pulse(rd_stat);
    f = frames;
    put(9'h066);
    tick(2);
    check("done after read and write", done, 0);
    wait_low();
    check("empty at frame start", empty, 1);
    wait_cnt(frames, f + 1);
    tick(2 * BIT);
    check("rts, done, irq", {rts_n, done, irq}, 3'h3);
    pulse(done_clr);
    tick(2);
    check("done written zero", {done, irq}, 2'h0);
    empty_on = 1'h1;
    tick(2);
    check("empty irq", irq, 1);
    ctrl.sync_mode = 1'h1;
    for (int b = 0; b < 2; b++) begin
      ctrl.last_bit_pulse = b[0];
      ctrl.clk_phase = b[0];
      f = frames;
      rises = 0;
      put(9'h0FF);
      wait_cnt(frames, f + 1);
      check("bit clock pulses", rises, 8 + b);
    end
    ctrl.sync_mode = 1'h0;
    ctrl.word_nine = 1'h0;
    tick(2 * BIT);
    check("done before disable", done, 1);
    f = frames;
    put(9'h000);
    wait_low();
    tick(2 * BIT);
    ctrl.transmit_enable_bit = 1'h0;
    wait_cnt(frames, f + 1);
    check("frame cut short", got, 9'h0FE);
    check("pin released", oe, 0);
    summarize();
  end
endmodule // testbench
